// ---- hdl/sft_transmitter.sv ----
// Notes on behaviour
// - The low phase of every pulse lasts either 5 or 3 ticks as configured.
// - A standard frame is status, three data nibbles, then the checksum.
// - A secure frame is status, three data, two counter, inverted, checksum.
// - With the slow message on, one message bit goes out per frame.
// - A chip error sets the status error bit and may also replace the data.
// - With in-data errors on, 4091 marks an error and data is held to 1..4088.
// - The tick lasts either 1.5 or 3.0 microseconds.
// - Status bit 0 flags error, self-test failure or reset; bit 1 is zero.
// - Status bit 2 is the message data bit and bit 3 its start mark.
// - The checksum covers the nibbles after status, never the status itself.
// - The checksum uses x4+x3+x2+1, starts at 0101, and its remainder is sent.
// - One further checksum step with a zero nibble ends the calculation.
// - Each step maps the state through the fixed table and XORs the nibble.
`timescale 1ns/1ps
module sft_transmitter
    import sft_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic lowTimeShort,
    input wire logic secureMode,
    input wire logic serialMsgEn,
    input wire logic errInDataEn,
    input wire logic tickSlow,
    input wire logic chipError,
    input wire logic selfTestFail,
    input wire logic [11:0] angleData,
    input wire logic angleValid,
    output logic angleReady,
    input wire logic [15:0] serialAngleBase,
    input wire logic [15:0] serialTemp,
    input wire logic [31:0] customerId,
    output logic sentOut,
    output logic frameDone,
    output logic [7:0] rollCount
);
    sft_state_e stateQ, stateD;
    logic [8:0] divQ, divD, tickCycQ, tickCycD;
    logic [5:0] tickQ, tickD, lowQ, lowD, ssmIdxQ, ssmIdxD;
    logic [3:0] idxQ, idxD, pulsesQ, pulsesD;
    sft_slots_t nibQ, nibD, build;
    logic [3:0] buildPulses;
    logic [7:0] rollQ, rollD, rollUse;
    logic secQ, secD, resetFlagQ, resetFlagD;
    logic outQ, outD, doneQ, doneD;
    logic [11:0] fifoData, angle;
    logic fifoValid, load, tickEnd, errAny;
    logic [5:0] pulseLen;
    logic [63:0] msg;

    sft_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) i_sft_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .inData(angleData),
        .inValid(angleValid),
        .inReady(angleReady),
        .outData(fifoData),
        .outValid(fifoValid),
        .outReady(load)
    );

    function automatic logic [3:0] crcFrame(input sft_slots_t s,
                                            input logic [3:0] crcSlot);
        logic [3:0] crc;
        crc = CRC_SEED;
        for (int i = SLOT_DATA; i < NUM_SLOTS - 1; i++) begin
            if (4'(i) < crcSlot) begin
                crc = crcStep(crc, s[i]);
            end
        end
        crcFrame = crcStep(crc, CRC_PAD);
    endfunction : crcFrame

    // Frame contents from the current inputs
    always_comb begin
        errAny = chipError | selfTestFail;
        rollUse = rollQ;
        if (stateQ == ST_HIGH && secQ) begin
            rollUse = rollQ + 8'h01;
        end
        angle = fifoData;
        if (errInDataEn) begin
            if (errAny) begin
                angle = ERR_CODE;
            end else if (fifoData < DATA_MIN) begin
                angle = DATA_MIN;
            end else if (fifoData > DATA_MAX) begin
                angle = DATA_MAX;
            end
        end
        msg = {customerId, serialTemp, serialAngleBase};
        build = '0;
        build[SLOT_STATUS][ST_ERR_BIT] = errAny | resetFlagQ;
        build[SLOT_STATUS][ST_RSVD_BIT] = 1'b0;
        if (serialMsgEn) begin
            build[SLOT_STATUS][ST_SSM_DATA_BIT] = msg[ssmIdxQ];
            build[SLOT_STATUS][ST_SSM_START_BIT] = ssmIdxQ == '0;
        end
        build[SLOT_DATA] = angle[11:8];
        build[SLOT_DATA+1] = angle[7:4];
        build[SLOT_DATA+2] = angle[3:0];
        if (secureMode) begin
            build[SLOT_RC] = rollUse[7:4];
            build[SLOT_RC+1] = rollUse[3:0];
            build[SLOT_INV] = ~angle[11:8];
            build[SLOT_SEC_CRC] = crcFrame(build, 4'(SLOT_SEC_CRC));
            buildPulses = PULSES_SEC;
        end else begin
            build[SLOT_STD_CRC] = crcFrame(build, 4'(SLOT_STD_CRC));
            buildPulses = PULSES_STD;
        end
    end

    // Pulse length of the current slot
    always_comb begin
        if (idxQ == '0) begin
            pulseLen = CAL_TICKS;
        end else begin
            pulseLen = NIB_BASE_TICKS + {2'h0, nibQ[idxQ]};
        end
        tickEnd = divQ == tickCycQ - 9'h001;
    end

    // Pulse sequencer
    always_comb begin
        stateD = stateQ;
        divD = divQ;
        tickD = tickQ;
        idxD = idxQ;
        nibD = nibQ;
        pulsesD = pulsesQ;
        lowD = lowQ;
        tickCycD = tickCycQ;
        secD = secQ;
        rollD = rollQ;
        ssmIdxD = ssmIdxQ;
        resetFlagD = resetFlagQ;
        outD = outQ;
        doneD = 1'b0;
        load = 1'b0;
        unique case (stateQ)
            ST_IDLE: begin
                outD = 1'b1;
                load = fifoValid;
            end
            ST_LOW: begin
                divD = tickEnd ? 9'h000 : divQ + 9'h001;
                if (tickEnd) begin
                    tickD = tickQ + 6'h01;
                    if (tickQ + 6'h01 == lowQ) begin
                        stateD = ST_HIGH;
                        outD = 1'b1;
                    end
                end
            end
            ST_HIGH: begin
                divD = tickEnd ? 9'h000 : divQ + 9'h001;
                if (tickEnd) begin
                    tickD = tickQ + 6'h01;
                    if (tickQ + 6'h01 == pulseLen) begin
                        if (idxQ == pulsesQ - 4'h1) begin
                            doneD = 1'b1;
                            if (secQ) begin
                                rollD = rollQ + 8'h01;
                            end
                            if (!serialMsgEn) begin
                                ssmIdxD = '0;
                            end else if (ssmIdxQ == SSM_LAST) begin
                                ssmIdxD = '0;
                            end else begin
                                ssmIdxD = ssmIdxQ + 6'h01;
                            end
                            stateD = ST_IDLE;
                            outD = 1'b1;
                            load = fifoValid;
                        end else begin
                            idxD = idxQ + 4'h1;
                            tickD = '0;
                            stateD = ST_LOW;
                            outD = 1'b0;
                        end
                    end
                end
            end
        endcase
        if (load) begin
            nibD = build;
            pulsesD = buildPulses;
            secD = secureMode;
            resetFlagD = 1'b0;
            lowD = lowTimeShort ? LOW_SHORT_TICKS : LOW_STD_TICKS;
            tickCycD = tickSlow ? TICK_SLOW_CYC : TICK_FAST_CYC;
            stateD = ST_LOW;
            divD = '0;
            tickD = '0;
            idxD = '0;
            outD = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stateQ <= ST_IDLE;
            divQ <= '0;
            tickQ <= '0;
            idxQ <= '0;
            nibQ <= '0;
            pulsesQ <= PULSES_STD;
            lowQ <= LOW_STD_TICKS;
            tickCycQ <= TICK_FAST_CYC;
            secQ <= 1'b0;
            rollQ <= '0;
            ssmIdxQ <= '0;
            resetFlagQ <= 1'b1;
            outQ <= 1'b1;
            doneQ <= 1'b0;
        end else if (clkEn) begin
            stateQ <= stateD;
            divQ <= divD;
            tickQ <= tickD;
            idxQ <= idxD;
            nibQ <= nibD;
            pulsesQ <= pulsesD;
            lowQ <= lowD;
            tickCycQ <= tickCycD;
            secQ <= secD;
            rollQ <= rollD;
            ssmIdxQ <= ssmIdxD;
            resetFlagQ <= resetFlagD;
            outQ <= outD;
            doneQ <= doneD;
        end
    end

    assign sentOut = outQ;
    assign frameDone = doneQ;
    assign rollCount = rollQ;

    // Checking helpers
    logic [10:0] lowRunQ;
    logic [3:0] risesQ;
    logic firstCyc;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lowRunQ <= '0;
            risesQ <= '0;
        end else if (clkEn) begin
            lowRunQ <= outQ ? 11'h000 : lowRunQ + 11'h001;
            if (doneQ) begin
                risesQ <= '0;
            end else if (!outQ && outD) begin
                risesQ <= risesQ + 4'h1;
            end
        end
    end

    assign firstCyc = stateQ == ST_LOW && idxQ == '0 && tickQ == '0 &&
                      divQ == '0;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    low_phase_a: assert property (
        $rose(sentOut) |-> lowRunQ == 11'(lowQ) * 11'(tickCycQ))
        else $error("low phase length wrong");

    frame_len_a: assert property (
        frameDone |-> risesQ == ($past(secQ) ? PULSES_SEC : PULSES_STD))
        else $error("pulse count per frame wrong");

    crc_known_a: assert property (
        firstCyc && !secQ && nibQ[SLOT_DATA] == 4'h7 &&
        nibQ[SLOT_DATA+1] == 4'h4 && nibQ[SLOT_DATA+2] == 4'h8
        |-> nibQ[SLOT_STD_CRC] == 4'h8)
        else $error("checksum mismatch on known data");

    err_code_a: assert property (
        firstCyc && $past(clkEn && errInDataEn && chipError)
        |-> {nibQ[SLOT_DATA], nibQ[SLOT_DATA+1], nibQ[SLOT_DATA+2]}
            == ERR_CODE)
        else $error("error code not sent");

    clamp_range_a: assert property (
        firstCyc && $past(clkEn && errInDataEn && !chipError &&
        !selfTestFail)
        |-> {nibQ[SLOT_DATA], nibQ[SLOT_DATA+1], nibQ[SLOT_DATA+2]}
            inside {[DATA_MIN:DATA_MAX]})
        else $error("data outside limited range");

    status_bits_a: assert property (
        firstCyc && $past(clkEn)
        |-> !nibQ[SLOT_STATUS][ST_RSVD_BIT] &&
            nibQ[SLOT_STATUS][ST_ERR_BIT] ==
            $past(chipError | selfTestFail | resetFlagQ))
        else $error("status error bit wrong");

    ssm_start_a: assert property (
        firstCyc && $past(clkEn)
        |-> nibQ[SLOT_STATUS][ST_SSM_START_BIT] ==
            $past(serialMsgEn && ssmIdxQ == '0))
        else $error("message start mark wrong");

    inverted_nib_a: assert property (
        firstCyc && secQ
        |-> nibQ[SLOT_INV] == ~nibQ[SLOT_DATA] &&
            {nibQ[SLOT_RC], nibQ[SLOT_RC+1]} == rollQ)
        else $error("secure nibbles wrong");

    roll_step_a: assert property (
        frameDone && $past(clkEn) && $past(secQ)
        |-> rollQ == $past(rollQ) + 8'h01)
        else $error("rolling counter did not step");
endmodule : sft_transmitter

// ---- hdl/sft_pkg.sv ----
package sft_pkg;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int TICK_FAST_NS = 1500;
    localparam int TICK_SLOW_NS = 3000;
    localparam logic [8:0] TICK_FAST_CYC =
        9'(TICK_FAST_NS * 1000 / CLK_PERIOD_PS);
    localparam logic [8:0] TICK_SLOW_CYC =
        9'(TICK_SLOW_NS * 1000 / CLK_PERIOD_PS);

    localparam int DATA_W = 12;
    localparam int NIB_W = 4;
    localparam int NUM_SLOTS = 9;
    localparam int FIFO_DEPTH = 8;

    localparam logic [5:0] LOW_STD_TICKS = 6'h05;
    localparam logic [5:0] LOW_SHORT_TICKS = 6'h03;
    localparam logic [5:0] CAL_TICKS = 6'h38;
    localparam logic [5:0] NIB_BASE_TICKS = 6'h0C;

    localparam logic [3:0] PULSES_STD = 4'h6;
    localparam logic [3:0] PULSES_SEC = 4'h9;

    localparam int SLOT_STATUS = 1;
    localparam int SLOT_DATA = 2;
    localparam int SLOT_STD_CRC = 5;
    localparam int SLOT_RC = 5;
    localparam int SLOT_INV = 7;
    localparam int SLOT_SEC_CRC = 8;

    localparam int ST_ERR_BIT = 0;
    localparam int ST_RSVD_BIT = 1;
    localparam int ST_SSM_DATA_BIT = 2;
    localparam int ST_SSM_START_BIT = 3;

    localparam logic [5:0] SSM_LAST = 6'h3F;

    localparam logic [11:0] ERR_CODE = 12'hFFB;
    localparam logic [11:0] DATA_MIN = 12'h001;
    localparam logic [11:0] DATA_MAX = 12'hFF8;

    localparam logic [3:0] CRC_SEED = 4'h5;
    localparam logic [3:0] CRC_PAD = 4'h0;
    localparam logic [15:0][3:0] CRC_TABLE = {
        4'h5, 4'h8, 4'h2, 4'hF, 4'hB, 4'h6, 4'hC, 4'h1,
        4'h4, 4'h9, 4'h3, 4'hE, 4'hA, 4'h7, 4'hD, 4'h0
    };

    typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} sft_state_e;
    typedef logic [NUM_SLOTS-1:0][NIB_W-1:0] sft_slots_t;

    function automatic logic [3:0] crcStep(input logic [3:0] state,
                                           input logic [3:0] nib);
        crcStep = CRC_TABLE[state] ^ nib;
    endfunction : crcStep
endpackage : sft_pkg

// ---- hdl/sft_fifo.sv ----
`timescale 1ns/1ps
module sft_fifo
    import sft_pkg::*;
#(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

    logic [DEPTH-1:0][WIDTH-1:0] memQ, memD;
    logic [PW-1:0] wrQ, wrD, rdQ, rdD;
    logic [PW:0] cntQ, cntD;
    logic inReadyQ, inReadyD, outValidQ, outValidD;
    logic push, pop;

    // Push and pop only through registered flags
    always_comb begin
        push = inValid && inReadyQ;
        pop = outReady && outValidQ;
        memD = memQ;
        wrD = wrQ;
        rdD = rdQ;
        cntD = cntQ;
        if (push) begin
            memD[wrQ] = inData;
            wrD = wrQ + 1'b1;
        end
        if (pop) begin
            rdD = rdQ + 1'b1;
        end
        if (push && !pop) begin
            cntD = cntQ + 1'b1;
        end else if (pop && !push) begin
            cntD = cntQ - 1'b1;
        end
        inReadyD = cntD != FULL;
        outValidD = cntD != '0;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            memQ <= '0;
            wrQ <= '0;
            rdQ <= '0;
            cntQ <= '0;
            inReadyQ <= 1'b0;
            outValidQ <= 1'b0;
        end else if (clkEn) begin
            memQ <= memD;
            wrQ <= wrD;
            rdQ <= rdD;
            cntQ <= cntD;
            inReadyQ <= inReadyD;
            outValidQ <= outValidD;
        end
    end

    assign inReady = inReadyQ;
    assign outValid = outValidQ;
    assign outData = memQ[rdQ];
endmodule : sft_fifo

// ---- verification/sft_sent_receiver.sv ----
`timescale 1ns/1ps
module sft_sent_receiver
    import sft_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic sentIn,
    input wire logic [8:0] tickCyc,
    input wire logic [5:0] lowTicks,
    output int badPulses,
    output int nibCount,
    output logic [15:0][3:0] nibs,
    output logic crcGood
);
    localparam logic [3:0] STEP_TAB [16] = '{4'h0, 4'hD, 4'h7, 4'hA,
        4'hE, 4'h3, 4'h9, 4'h4, 4'h1, 4'hC, 4'h6, 4'hB, 4'hF, 4'h2,
        4'h8, 4'h5};

    logic lineQ;
    logic inFrame;
    int cnt;
    int ticks;

    function automatic logic checkCrc(input logic [15:0][3:0] n,
                                      input int cntN);
        logic [3:0] crc;
        crc = 4'h5;
        for (int i = 1; i < cntN - 1; i++) begin
            crc = STEP_TAB[crc] ^ n[i];
        end
        crc = STEP_TAB[crc];
        return crc === n[cntN-1];
    endfunction : checkCrc

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lineQ = 1'b1;
            inFrame = 1'b0;
            cnt = 0;
            badPulses = 0;
            nibCount = 0;
            nibs = '0;
            crcGood = 1'b0;
        end else begin
            if (lineQ && !sentIn) begin
                if (inFrame) begin
                    ticks = cnt / int'(tickCyc);
                    if (cnt % int'(tickCyc) != 0) badPulses++;
                    if (ticks == 56) begin
                        nibCount = 0;
                    end else if (ticks < 12 || ticks > 27) begin
                        badPulses++;
                    end else if (nibCount < 16) begin
                        nibs[nibCount] = 4'(ticks - 12);
                        nibCount++;
                        crcGood = checkCrc(nibs, nibCount);
                    end
                end
                inFrame = 1'b1;
                cnt = 1;
            end else begin
                if (!lineQ && sentIn && inFrame) begin
                    if (cnt != int'(lowTicks) * int'(tickCyc)) badPulses++;
                end
                cnt++;
            end
            lineQ = sentIn;
        end
    end
endmodule : sft_sent_receiver

// ---- verification/sft_transmitter_bench.sv ----
`timescale 1ns/1ps
module sft_transmitter_bench
    import sft_pkg::*;
;
    logic clk, reset_n, lowTimeShort, secureMode, serialMsgEn;
    logic errInDataEn, tickSlow, chipError, selfTestFail;
    logic [11:0] angleData;
    logic angleValid, angleReady, sentOut, frameDone;
    logic [15:0] serialAngleBase, serialTemp;
    logic [31:0] customerId;
    logic [7:0] rollCount, prevRc;
    logic [8:0] tickCyc;
    logic [5:0] lowTicks;
    int badPulses, nibCount, mismatches, comparisons, n, accepted;
    logic [15:0][3:0] nibs;
    logic crcGood;

    sft_transmitter i_sft_transmitter (.clk(clk), .reset_n(reset_n),
        .clkEn(1'b1), .lowTimeShort(lowTimeShort), .secureMode(secureMode),
        .serialMsgEn(serialMsgEn), .errInDataEn(errInDataEn),
        .tickSlow(tickSlow), .chipError(chipError),
        .selfTestFail(selfTestFail), .angleData(angleData),
        .angleValid(angleValid), .angleReady(angleReady),
        .serialAngleBase(serialAngleBase), .serialTemp(serialTemp),
        .customerId(customerId), .sentOut(sentOut),
        .frameDone(frameDone), .rollCount(rollCount));

    sft_sent_receiver i_sft_sent_receiver (.clk(clk), .reset_n(reset_n),
        .sentIn(sentOut), .tickCyc(tickCyc), .lowTicks(lowTicks),
        .badPulses(badPulses), .nibCount(nibCount), .nibs(nibs),
        .crcGood(crcGood));

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: %s got %0h expected %0h", $time, what,
                     got, exp);
        end
    endtask : check

    task automatic timedOut(input string what);
        mismatches++;
        $display("ERROR %0t: timeout waiting for %s", $time, what);
        conclude();
    endtask : timedOut

    task automatic pushWord(input logic [11:0] d);
        int k;
        k = 0;
        while (angleReady !== 1'b1 && k < 100) begin
            @(negedge clk);
            k++;
        end
        if (k >= 100) timedOut("write ready");
        angleValid = 1'b1;
        angleData = d;
        @(negedge clk);
        angleValid = 1'b0;
        @(negedge clk);
    endtask : pushWord

    task automatic waitFrame();
        int k;
        k = 0;
        while (frameDone !== 1'b1 && k < 45000) begin
            @(negedge clk);
            k++;
        end
        if (k >= 45000) timedOut("frame end");
        repeat (2) @(negedge clk);
    endtask : waitFrame

    task automatic checkFrame(input int cntN, input logic [8:0][3:0] exp,
                              input logic [8:0] sel);
        check(32'(nibCount), 32'(cntN), "nibble count");
        check(32'(crcGood), 32'h1, "checksum");
        check(32'(badPulses), 32'h0, "pulse shape");
        for (int i = 0; i < 9; i++) begin
            if (sel[i]) check(32'(nibs[i]), 32'(exp[i]), "nibble");
        end
    endtask : checkFrame

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        reset_n = 1'b0;
        {lowTimeShort, secureMode, serialMsgEn, errInDataEn} = 4'h0;
        {tickSlow, chipError, selfTestFail, angleValid} = 4'h0;
        angleData = 12'h000;
        serialAngleBase = 16'h0001;
        serialTemp = 16'hA5C3;
        customerId = 32'h1234ABCD;
        tickCyc = TICK_FAST_CYC;
        lowTicks = LOW_STD_TICKS;
        mismatches = 0;
        comparisons = 0;
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        pushWord(12'h748);
        pushWord(12'h123);
        repeat (200) @(negedge clk);
        {secureMode, lowTimeShort, errInDataEn, chipError} = 4'hF;
        serialMsgEn = 1'b1;
        waitFrame();
        checkFrame(5, 36'h000088471, 9'h01F);
        $display("test standard frame done");
        lowTicks = LOW_SHORT_TICKS;
        {lowTimeShort, chipError, errInDataEn, selfTestFail} = 4'h1;
        pushWord(12'h000);
        waitFrame();
        checkFrame(8, 36'h00000BFFD, 9'h04F);
        prevRc = {nibs[4], nibs[5]};
        $display("test secure error frame done");
        lowTicks = LOW_STD_TICKS;
        {tickSlow, selfTestFail, secureMode} = 3'h4;
        pushWord(12'h456);
        waitFrame();
        checkFrame(8, 36'h00F000001, 9'h04F);
        check(32'({nibs[4], nibs[5]}), 32'(prevRc + 8'h01), "counter");
        check(32'(rollCount), 32'(prevRc + 8'h02), "counter out");
        $display("test secure counter frame done");
        tickCyc = TICK_SLOW_CYC;
        n = 0;
        while (sentOut === 1'b0 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 3000) timedOut("slow low end");
        check(32'(n + 2), 32'(LOW_STD_TICKS) * 32'(TICK_SLOW_CYC), "low");
        repeat (2) @(negedge clk);
        check(32'(badPulses), 32'h0, "slow tick low phase");
        $display("test slow tick done");
        reset_n = 1'b0;
        @(negedge clk);
        check(32'({sentOut, angleReady, frameDone}), 32'h4, "reset outs");
        check(32'(rollCount), 32'h0, "reset counter");
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        tickSlow = 1'b0;
        tickCyc = TICK_FAST_CYC;
        repeat (2) @(negedge clk);
        accepted = 0;
        angleValid = 1'b1;
        errInDataEn = 1'b1;
        angleData = 12'hFFF;
        for (int i = 0; i < 12; i++) begin
            if (angleReady === 1'b1) accepted++;
            @(negedge clk);
        end
        angleValid = 1'b0;
        check(32'(accepted), 32'd9, "words taken");
        check(32'(angleReady), 32'h0, "full refuses");
        $display("test buffer fill done");
        conclude();
    end
endmodule : sft_transmitter_bench
